// >>> e1csr_pkg.sv
// Purpose: Shared constants and types for the E1 control and status registers.
// Assumes: Eight-bit register port, one system clock.
// Notes:   Status index 0 is status_one, 1 is status_two, 2 is receive_info.
package e1csr_pkg;
    localparam logic [7:0] E1CSR_A_SR1  = 8'h06;
    localparam logic [7:0] E1CSR_A_SR2  = 8'h07;
    localparam logic [7:0] E1CSR_A_RIR  = 8'h08;
    localparam logic [7:0] E1CSR_A_TRANSMIT_CONTROL_TWO = 8'h13;
    localparam logic [7:0] E1CSR_A_CCR  = 8'h14;
    localparam logic [7:0] E1CSR_A_INTERRUPT_MASK_ONE = 8'h16;
    localparam logic [7:0] E1CSR_A_INTERRUPT_MASK_TWO = 8'h17;
    localparam logic [7:0] E1CSR_A_SSR  = 8'h1E;
    localparam logic [7:0] E1CSR_RST    = 8'h00;
    localparam logic [7:0] E1CSR_TRANSMIT_CONTROL_TWO_WMASK = 8'hFB;
    localparam int E1CSR_SA_LO  = 3;
    localparam int E1CSR_SA_HI  = 7;
    localparam int E1CSR_AUTO_EBIT_ENABLE   = 1;
    localparam int E1CSR_PINF   = 0;
    localparam int E1CSR_LLB    = 7;
    localparam int E1CSR_TCODE  = 6;
    localparam int E1CSR_TBLK   = 5;
    localparam int E1CSR_TCHK   = 4;
    localparam int E1CSR_RSM    = 3;
    localparam int E1CSR_RCODE  = 2;
    localparam int E1CSR_RBLK   = 1;
    localparam int E1CSR_RCHK   = 0;
    localparam int E1CSR_NSTAT  = 3;
    localparam int E1CSR_NIRQ   = 2;

    typedef struct packed {
        logic positive;
        logic negative;
        logic bit_en;
    } e1csr_line_t;

    typedef struct packed {
        logic [7:0]                        transmit_control_two;
        logic [7:0]                        common_control;
        logic [E1CSR_NIRQ-1:0][7:0]        imr;
        logic [E1CSR_NSTAT-1:0][7:0]       latch;
        logic [E1CSR_NSTAT-1:0][7:0]       hold;
        logic [7:0]                        rdata;
        logic [E1CSR_NIRQ-1:0]             irq;
        logic                              status_pin;
        logic                              tx_spare;
        logic                              spare_from_link;
        logic                              tx_blk;
        logic                              rx_blk;
        e1csr_line_t                       rx_line;
    } e1csr_state_t;
endpackage

// >>> e1csr_regs.sv
// Purpose: Control registers, latched status scheme and loopback steering of an E1 framer.
// Assumes: Synchronous register port; line bit rates arrive as one-cycle bit enables.
// Notes:   Read data appears one cycle after the read strobe.
`timescale 1ns/1ns
`default_nettype none

module e1csr_regs
    import e1csr_pkg::*;
(
    // Clock and reset.
    input  wire logic        i_clock,
    input  wire logic        i_srst,
    // Register port.
    input  wire logic [7:0]  i_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [7:0]  o_rdata,
    // Status sources.
    input  wire logic [7:0]  i_status_one_event,
    input  wire logic [7:0]  i_status_two_event,
    input  wire logic [7:0]  i_receive_info_event,
    input  wire logic [7:0]  i_synchronizer_state,
    input  wire logic        i_receive_sync_loss,
    input  wire logic        i_transmit_clock_loss,
    // Transmit and receive framing.
    input  wire logic [4:0]  i_spare_slot,
    input  wire logic        i_transmit_link_input,
    input  wire logic        i_internal_spare,
    input  wire logic        i_tx_ts26_bit1,
    input  wire logic        i_tx_block_base,
    input  wire logic        i_rx_ts26_bit1,
    input  wire logic        i_rx_block_base,
    // Line sides.
    input  wire e1csr_line_t i_rx_line,
    input  wire e1csr_line_t i_tx_line,
    output e1csr_line_t      o_rx_line,
    // Control and status outputs.
    output logic             o_tx_spare_bit,
    output logic             o_spare_from_link,
    output logic             o_auto_ebit_enable,
    output logic             o_status_pin,
    output logic             o_tx_channel_block_out,
    output logic             o_rx_channel_block_out,
    output logic             o_rx_signaling_mode,
    output logic             o_local_loopback_enable,
    output logic             o_tx_line_code_enable,
    output logic             o_rx_line_code_enable,
    output logic             o_tx_check_enable,
    output logic             o_rx_check_enable,
    output logic             o_interrupt_out_one,
    output logic             o_interrupt_out_two
);
    e1csr_state_t st_r;
    e1csr_state_t st_nxt;
    logic [E1CSR_NSTAT-1:0][7:0] ev;
    logic [E1CSR_NSTAT-1:0]      st_wr;

    assign ev[0] = i_status_one_event;
    assign ev[1] = i_status_two_event;
    assign ev[2] = i_receive_info_event;
    assign st_wr[0] = i_wr && (i_addr == E1CSR_A_SR1);
    assign st_wr[1] = i_wr && (i_addr == E1CSR_A_SR2);
    assign st_wr[2] = i_wr && (i_addr == E1CSR_A_RIR);

    always_comb begin
        st_nxt = st_r;
        if (i_wr) begin
            case (i_addr)
                E1CSR_A_TRANSMIT_CONTROL_TWO: st_nxt.transmit_control_two = i_wdata & E1CSR_TRANSMIT_CONTROL_TWO_WMASK;
                E1CSR_A_CCR:  st_nxt.common_control = i_wdata;
                E1CSR_A_INTERRUPT_MASK_ONE: st_nxt.imr[0] = i_wdata;
                E1CSR_A_INTERRUPT_MASK_TWO: st_nxt.imr[1] = i_wdata;
                default:      st_nxt.common_control = st_r.common_control;
            endcase
        end
        for (int k = 0; k < E1CSR_NSTAT; k++) begin
            st_nxt.latch[k] = st_r.latch[k] | ev[k];
            if (st_wr[k]) begin
                st_nxt.hold[k] = (st_r.hold[k] & ~i_wdata) | ((st_r.latch[k] | ev[k]) & i_wdata);
                st_nxt.latch[k] = (st_r.latch[k] & ~i_wdata) | ev[k];
            end
        end
        for (int k = 0; k < E1CSR_NIRQ; k++) begin
            st_nxt.irq[k] = |(st_nxt.latch[k] & st_r.imr[k]);
        end
        if (i_rd) begin
            case (i_addr)
                E1CSR_A_SR1:  st_nxt.rdata = st_r.hold[0];
                E1CSR_A_SR2:  st_nxt.rdata = st_r.hold[1];
                E1CSR_A_RIR:  st_nxt.rdata = st_r.hold[2];
                E1CSR_A_TRANSMIT_CONTROL_TWO: st_nxt.rdata = st_r.transmit_control_two;
                E1CSR_A_CCR:  st_nxt.rdata = st_r.common_control;
                E1CSR_A_INTERRUPT_MASK_ONE: st_nxt.rdata = st_r.imr[0];
                E1CSR_A_INTERRUPT_MASK_TWO: st_nxt.rdata = st_r.imr[1];
                E1CSR_A_SSR:  st_nxt.rdata = i_synchronizer_state;
                default:      st_nxt.rdata = E1CSR_RST;
            endcase
        end
        st_nxt.spare_from_link = |(i_spare_slot & st_r.transmit_control_two[E1CSR_SA_HI:E1CSR_SA_LO]);
        st_nxt.tx_spare = st_nxt.spare_from_link ? i_transmit_link_input : i_internal_spare;
        st_nxt.status_pin = st_r.transmit_control_two[E1CSR_PINF] ? i_transmit_clock_loss : i_receive_sync_loss;
        st_nxt.tx_blk = i_tx_block_base | (st_r.common_control[E1CSR_TBLK] & i_tx_ts26_bit1);
        st_nxt.rx_blk = i_rx_block_base | (st_r.common_control[E1CSR_RBLK] & i_rx_ts26_bit1);
        st_nxt.rx_line = st_r.common_control[E1CSR_LLB] ? i_tx_line : i_rx_line;
        if (i_srst) begin
            st_nxt = '0;
        end
    end

    always_ff @(posedge i_clock) begin
        st_r <= st_nxt;
    end

    assign o_rdata = st_r.rdata;
    assign o_rx_line = st_r.rx_line;
    assign o_tx_spare_bit = st_r.tx_spare;
    assign o_spare_from_link = st_r.spare_from_link;
    assign o_auto_ebit_enable = st_r.transmit_control_two[E1CSR_AUTO_EBIT_ENABLE];
    assign o_status_pin = st_r.status_pin;
    assign o_tx_channel_block_out = st_r.tx_blk;
    assign o_rx_channel_block_out = st_r.rx_blk;
    assign o_rx_signaling_mode = st_r.common_control[E1CSR_RSM];
    assign o_local_loopback_enable = st_r.common_control[E1CSR_LLB];
    assign o_tx_line_code_enable = st_r.common_control[E1CSR_TCODE];
    assign o_rx_line_code_enable = st_r.common_control[E1CSR_RCODE];
    assign o_tx_check_enable = st_r.common_control[E1CSR_TCHK];
    assign o_rx_check_enable = st_r.common_control[E1CSR_RCHK];
    assign o_interrupt_out_one = st_r.irq[0];
    assign o_interrupt_out_two = st_r.irq[1];

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_srst);

    spare_link_a: assert property (
        (|(i_spare_slot & st_r.transmit_control_two[E1CSR_SA_HI:E1CSR_SA_LO])) |=> o_tx_spare_bit == $past(i_transmit_link_input)
    ) else $error("spare bit not taken from link");

    spare_int_a: assert property (
        (i_spare_slot & st_r.transmit_control_two[E1CSR_SA_HI:E1CSR_SA_LO]) == 5'h00 |=> o_tx_spare_bit == $past(i_internal_spare)
    ) else $error("spare bit taken from link when not selected");

    auto_ebit_a: assert property (
        i_wr && i_addr == E1CSR_A_TRANSMIT_CONTROL_TWO |=> o_auto_ebit_enable == $past(i_wdata[E1CSR_AUTO_EBIT_ENABLE])
    ) else $error("auto E-bit enable not updated");

    status_pin_a: assert property (
        ##1 o_status_pin == ($past(st_r.transmit_control_two[E1CSR_PINF]) ? $past(i_transmit_clock_loss) : $past(i_receive_sync_loss))
    ) else $error("status pin shows wrong source");

    tx_blank_a: assert property (
        st_r.common_control[E1CSR_TBLK] && i_tx_ts26_bit1 |=> o_tx_channel_block_out
    ) else $error("transmit block not forced in slot 26");

    rx_blank_a: assert property (
        !st_r.common_control[E1CSR_RBLK] && !i_rx_block_base |=> !o_rx_channel_block_out
    ) else $error("receive block forced while blanking off");

    sig_mode_a: assert property (
        i_wr && i_addr == E1CSR_A_CCR |=> o_rx_signaling_mode == $past(i_wdata[E1CSR_RSM])
    ) else $error("signaling mode not updated");

    loop_data_a: assert property (
        st_r.common_control[E1CSR_LLB] |=> o_rx_line == $past(i_tx_line)
    ) else $error("loopback does not carry transmit line");

    sticky_bit_a: assert property (
        st_r.latch[0][0] && !st_wr[0] |=> st_r.latch[0][0] [*1]
    ) else $error("latched status bit lost without write");

    rearm_a: assert property (
        st_wr[0] && i_status_one_event[0] |=> st_r.latch[0][0]
    ) else $error("event during clear was lost");

    refresh_a: assert property (
        st_wr[1] && i_wdata[0] && !i_status_two_event[0] |=> st_r.hold[1][0] == $past(st_r.latch[1][0])
            && !st_r.latch[1][0]
    ) else $error("masked write did not refresh and clear");

    hold_keep_a: assert property (
        st_wr[0] |=> ((st_r.hold[0] ^ $past(st_r.hold[0])) & ~$past(i_wdata)) == 8'h00
    ) else $error("unmasked read value changed");

    ssr_live_a: assert property (
        i_rd && i_addr == E1CSR_A_SSR |=> o_rdata == $past(i_synchronizer_state)
    ) else $error("synchronizer read not live");

    irq_one_a: assert property (
        o_interrupt_out_one == |(st_r.latch[0] & $past(st_r.imr[0]))
    ) else $error("interrupt one does not follow status one");

    irq_mask_a: assert property (
        st_r.imr[1] == 8'h00 && !(i_wr && i_addr == E1CSR_A_INTERRUPT_MASK_TWO) |=> !o_interrupt_out_two
    ) else $error("masked event reached interrupt two");

    irq_hold_a: assert property (
        (st_r.latch[1] & st_r.imr[1]) != 8'h00 && !st_wr[1] && !(i_wr && i_addr == E1CSR_A_INTERRUPT_MASK_TWO)
            |=> o_interrupt_out_two ##1 (o_interrupt_out_two || $past(st_wr[1])
            || $past(i_wr && i_addr == E1CSR_A_INTERRUPT_MASK_TWO))
    ) else $error("interrupt two released while pending");

endmodule

`default_nettype wire

// >>> e1csr_host.sv
// Purpose: Host processor model on the register port.
// Assumes: Strobes change at the falling edge and last one cycle.
// Notes:   Status polls keep the mask, read, write-back order.
`timescale 1ns/1ns
`default_nettype none
module e1csr_host
    import e1csr_pkg::*;
(
    // Bus side.
    input  wire logic       i_clock,
    input  wire logic [7:0] i_rdata,
    output logic      [7:0] o_addr,
    output logic      [7:0] o_wdata,
    output logic            o_wr,
    output logic            o_rd
);
    initial begin
        o_addr = 8'h00;
        o_wdata = 8'h00;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clock);
        o_addr = a;
        o_wdata = (a == E1CSR_A_TRANSMIT_CONTROL_TWO) ? (d & E1CSR_TRANSMIT_CONTROL_TWO_WMASK) : d;
        o_wr = 1'b1;
        @(negedge i_clock);
        o_wr = 1'b0;
        o_wdata = ~o_wdata;
    endtask
    task automatic rd(input logic [7:0] a);
        @(negedge i_clock);
        o_addr = a;
        o_rd = 1'b1;
        @(negedge i_clock);
        o_rd = 1'b0;
    endtask
    task automatic poll(input logic [7:0] a, input logic [7:0] m);
        wr(a, m);
        rd(a);
        wr(a, i_rdata & m);
    endtask
endmodule
`default_nettype wire

// >>> e1csr_regs_tb.sv
// Purpose: Self-checking bench for the E1 control and status registers.
// Assumes: Host model drives the port at the falling edge.
// Notes:   Read bytes are matched against a queue of expected values.
`timescale 1ns/1ns
`default_nettype none
module e1csr_regs_tb;
    import e1csr_pkg::*;
    logic        clk, srst, wr, rd, sl, cl, link, intsp, tts, tbase, rts, rbase;
    logic        spare, flink, auto_ebit_enable, pin, tblk, rblk, rx_signaling_mode, local_loopback_enable, tcode, rcode, tchk, rchk, irq1, irq2;
    logic        rd_seen = 1'b0;
    logic [7:0]  addr, wdata, rdata, sync_st;
    logic [7:0]  ev [3];
    logic [4:0]  slot;
    e1csr_line_t rxl, txl, rxo;
    int          err_total, samples_checked, cyc, k;
    integer      seed;
    logic [31:0] r;
    logic [7:0]  exp_q [$];
    logic [7:0]  at [3] = '{E1CSR_A_SR1, E1CSR_A_SR2, E1CSR_A_RIR};
    logic [1:0]  irq_p [3] = '{2'b01, 2'b00, 2'b00};
    logic [1:0]  irq_l [3] = '{2'b00, 2'b10, 2'b00};

    e1csr_host host (.i_clock(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
    e1csr_regs DUT (
        .i_clock(clk), .i_srst(srst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .i_status_one_event(ev[0]), .i_status_two_event(ev[1]), .i_receive_info_event(ev[2]),
        .i_synchronizer_state(sync_st), .i_receive_sync_loss(sl), .i_transmit_clock_loss(cl),
        .i_spare_slot(slot), .i_transmit_link_input(link), .i_internal_spare(intsp), .i_tx_ts26_bit1(tts),
        .i_tx_block_base(tbase), .i_rx_ts26_bit1(rts), .i_rx_block_base(rbase), .i_rx_line(rxl),
        .i_tx_line(txl), .o_rx_line(rxo), .o_tx_spare_bit(spare), .o_spare_from_link(flink),
        .o_auto_ebit_enable(auto_ebit_enable), .o_status_pin(pin), .o_tx_channel_block_out(tblk),
        .o_rx_channel_block_out(rblk), .o_rx_signaling_mode(rx_signaling_mode), .o_local_loopback_enable(local_loopback_enable),
        .o_tx_line_code_enable(tcode), .o_rx_line_code_enable(rcode), .o_tx_check_enable(tchk),
        .o_rx_check_enable(rchk), .o_interrupt_out_one(irq1), .o_interrupt_out_two(irq2)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] want);
        samples_checked++;
        if (seen !== want) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic rx(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host.rd(a);
    endtask
    // An empty queue pops unknown, so a stray read always mismatches.
    always @(posedge clk) rd_seen <= rd;
    always @(negedge clk) if (rd_seen) chk(rdata, exp_q.pop_front());
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_total++;
            conclude();
        end
    end

    initial begin
        seed = 32'h3c68f812;
        srst = 1'b1;
        {slot, sl, cl, link, intsp, tts, tbase, rts, rbase} = '0;
        rxl = '0;
        txl = '0;
        ev = '{default: 8'h00};
        sync_st = 8'h00;
        repeat (8) @(negedge clk);
        srst = 1'b0;
        for (k = 0; k < 3; k++) rx(at[k], 8'h00);
        rx(E1CSR_A_CCR, 8'h00);
        for (int i = 0; i < 20; i++) begin
            r = $random(seed);
            host.wr(E1CSR_A_TRANSMIT_CONTROL_TWO, r[7:0]);
            host.wr(E1CSR_A_CCR, r[15:8]);
            rx(E1CSR_A_TRANSMIT_CONTROL_TWO, r[7:0] & 8'hFB);
            rx(E1CSR_A_CCR, r[15:8]);
            slot = 5'h01 << (i % 5);
            {link, sl, cl, tts, tbase, rts, rbase} = r[22:16];
            intsp = ~link;
            rxl = e1csr_line_t'(r[25:23]);
            txl = e1csr_line_t'(r[28:26]);
            @(negedge clk);
            chk(flink, r[3 + i % 5]);
            chk(spare, r[3 + i % 5] ? link : intsp);
            chk(auto_ebit_enable, r[1]);
            chk(pin, r[0] ? cl : sl);
            chk(tblk, tbase | (r[13] & tts));
            chk(rblk, rbase | (r[9] & rts));
            chk({rx_signaling_mode, local_loopback_enable, tcode, tchk, rcode, rchk}, {r[11], r[15:14], r[12], r[10], r[8]});
            chk(rxo, r[15] ? txl : rxl);
        end
        host.wr(E1CSR_A_INTERRUPT_MASK_ONE, 8'h01);
        host.wr(E1CSR_A_INTERRUPT_MASK_TWO, 8'h80);
        sync_st = r[7:0];
        rx(E1CSR_A_SSR, r[7:0]);
        host.wr(E1CSR_A_SSR, ~r[7:0]);
        rx(E1CSR_A_SSR, r[7:0]);
        rx(8'h00, 8'h00);
        for (k = 0; k < 3; k++) begin
            @(negedge clk);
            ev[k] = 8'h03;
            @(negedge clk);
            ev[k] = 8'h00;
            chk({irq2, irq1}, irq_p[k]);
            exp_q.push_back(8'h01);
            host.poll(at[k], 8'h01);
            chk({irq2, irq1}, 2'b00);
            host.wr(at[k], 8'h02);
            rx(at[k], 8'h02);
            host.wr(at[k], 8'h01);
            rx(at[k], 8'h02);
            host.wr(at[k], 8'h02);
            rx(at[k], 8'h00);
            ev[k] = 8'h80;
            exp_q.push_back(8'h80);
            host.poll(at[k], 8'h80);
            chk({irq2, irq1}, irq_l[k]);
            rx(at[k], 8'h80);
            ev[k] = 8'h00;
            host.wr(at[k], 8'h80);
            host.wr(at[k], 8'h80);
            rx(at[k], 8'h00);
        end
        @(negedge clk);
        conclude();
    end
endmodule
`default_nettype wire
